// *** verilog/eaw_area_ctrl.sv ***
// External area access controller with programmable wait and hold timing.
// Assumes an AHB-Lite master with single word transfers and a synchronous
// external bus whose wait input is active low.
//
// Operation
// - The wait code gives the number of read wait cycles; 0001 is one.
// - Codes 0100 to 1100 give 4,5,6,8,10,12,14,18 and 24 wait cycles.
// - Mask bit 6 at zero honours the wait input; at one ignores it.
// - The mask setting applies even when the programmed wait count is zero.
// - Timing bits 5 to 2 read as zero; software writes zeros there.
// - Hold code sets strobe negation to address and select negation delay.
// - Mask bit and upper hold bit reset to zero and are read/write.
`timescale 1ns/1ps
module eaw_area_ctrl
  import eaw_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  output logic      [15:0] ext_addr,
  output logic      [15:0] ext_data_o,
  output logic             ext_data_oe,
  input  wire logic [15:0] ext_data_i,
  output logic             area_select_n,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  output logic      [1:0]  byte_lane_strobe_n,
  input  wire logic        ext_wait_n
);

  // ---------------------------------------------------------------
  // Bus slave state
  // ---------------------------------------------------------------
  logic        wr_pend_q, wr_pend_d;
  logic        rd_pend_q, rd_pend_d;
  logic [7:0]  ofs_q, ofs_d;
  logic        hreadyout_q, hreadyout_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic        addr_ok;

  // ---------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------
  logic [3:0]  wait_code_q, wait_code_d;
  logic        external_wait_mask_q, external_wait_mask_d;
  logic [1:0]  hold_q, hold_d;
  logic [15:0] addr_q, addr_d;
  logic [15:0] wdata_q, wdata_d;
  logic        dir_q, dir_d;
  logic [1:0]  lanes_q, lanes_d;
  logic        done_q, done_d;
  logic [15:0] rdata_q, rdata_d;
  logic [7:0]  stretch_q, stretch_d;
  logic        start;

  // ---------------------------------------------------------------
  // Access engine state
  // ---------------------------------------------------------------
  eaw_state_t       state_q, state_d;
  logic             cnt_load;
  logic [CNT_W-1:0] cnt_val;
  logic             cnt_zero;
  logic [4:0]       waits;
  logic             finish;
  logic [15:0]      ext_addr_q, ext_addr_d;
  logic [15:0]      ext_data_o_q, ext_data_o_d;
  logic             ext_data_oe_q, ext_data_oe_d;
  logic             area_sel_n_q, area_sel_n_d;
  logic             rd_stb_n_q, rd_stb_n_d;
  logic             wr_stb_n_q, wr_stb_n_d;
  logic [1:0]       lane_n_q, lane_n_d;

  function automatic logic ofs_mapped(input logic [7:0] ofs);
    ofs_mapped = (ofs == OFS_TIMING) || (ofs == OFS_ADDR) || (ofs == OFS_WDATA) ||
                 (ofs == OFS_CTRL) || (ofs == OFS_RDATA) || (ofs == OFS_STRETCH);
  endfunction : ofs_mapped

  function automatic logic strobe_phase(input eaw_state_t st);
    strobe_phase = (st == ST_WAIT) || (st == ST_EXTW);
  endfunction : strobe_phase

  // ---------------------------------------------------------------
  // Bus slave
  // ---------------------------------------------------------------
  assign addr_ok = hsel && htrans[1] && hready && (hsize == 3'h2);

  always_comb begin
    wr_pend_d   = 1'b0;
    rd_pend_d   = 1'b0;
    ofs_d       = ofs_q;
    hreadyout_d = 1'b1;
    hrdata_d    = hrdata_q;
    if (addr_ok) begin
      ofs_d       = haddr[7:0];
      wr_pend_d   = hwrite && ofs_mapped(haddr[7:0]);
      rd_pend_d   = !hwrite;
      hreadyout_d = hwrite;
    end
    if (rd_pend_q) begin
      hrdata_d = '0;
      case (ofs_q)
        OFS_TIMING: begin
          hrdata_d[POS_WAIT_CODE +: 4] = wait_code_q;
          hrdata_d[POS_WAIT_MASK]      = external_wait_mask_q;
          hrdata_d[POS_HOLD +: 2]      = hold_q;
        end
        OFS_ADDR:    hrdata_d[15:0] = addr_q;
        OFS_WDATA:   hrdata_d[15:0] = wdata_q;
        OFS_CTRL: begin
          hrdata_d[POS_BUSY]      = (state_q != ST_IDLE);
          hrdata_d[POS_DONE]      = done_q;
          hrdata_d[POS_DIR + 2]   = dir_q;
          hrdata_d[POS_LANES +: 2] = lanes_q;
        end
        OFS_RDATA:   hrdata_d[15:0] = rdata_q;
        OFS_STRETCH: hrdata_d[7:0]  = stretch_q;
        default:     hrdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_pend_q   <= 1'b0;
      rd_pend_q   <= 1'b0;
      ofs_q       <= 8'h00;
      hreadyout_q <= 1'b1;
      hrdata_q    <= 32'h0000_0000;
    end else begin
      wr_pend_q   <= wr_pend_d;
      rd_pend_q   <= rd_pend_d;
      ofs_q       <= ofs_d;
      hreadyout_q <= hreadyout_d;
      hrdata_q    <= hrdata_d;
    end
  end

  // ---------------------------------------------------------------
  // Register writes
  // ---------------------------------------------------------------
  assign start = wr_pend_q && (ofs_q == OFS_CTRL) && hwdata[POS_START] && (state_q == ST_IDLE);

  always_comb begin
    wait_code_d          = wait_code_q;
    external_wait_mask_d = external_wait_mask_q;
    hold_d               = hold_q;
    addr_d               = addr_q;
    wdata_d              = wdata_q;
    dir_d                = dir_q;
    lanes_d              = lanes_q;
    done_d               = done_q;
    if (wr_pend_q) begin
      case (ofs_q)
        OFS_TIMING: begin
          wait_code_d          = hwdata[POS_WAIT_CODE +: 4];
          external_wait_mask_d = hwdata[POS_WAIT_MASK];
          hold_d               = hwdata[POS_HOLD +: 2];
        end
        OFS_ADDR:  addr_d  = hwdata[15:0];
        OFS_WDATA: wdata_d = hwdata[15:0];
        OFS_CTRL: begin
          if (hwdata[POS_CLEAR]) begin
            done_d = 1'b0;
          end
          if (state_q == ST_IDLE) begin
            dir_d   = hwdata[POS_DIR];
            lanes_d = hwdata[POS_LANES +: 2];
          end
        end
        default: done_d = done_q;
      endcase
    end
    if (finish) begin
      done_d = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wait_code_q          <= RST_WAIT_CODE;
      external_wait_mask_q <= RST_WAIT_MASK;
      hold_q               <= RST_HOLD;
      addr_q               <= 16'h0000;
      wdata_q              <= 16'h0000;
      dir_q                <= 1'b0;
      lanes_q              <= RST_LANES;
      done_q               <= 1'b0;
    end else begin
      wait_code_q          <= wait_code_d;
      external_wait_mask_q <= external_wait_mask_d;
      hold_q               <= hold_d;
      addr_q               <= addr_d;
      wdata_q              <= wdata_d;
      dir_q                <= dir_d;
      lanes_q              <= lanes_d;
      done_q               <= done_d;
    end
  end

  // ---------------------------------------------------------------
  // Access engine
  // ---------------------------------------------------------------
  eaw_wait_decode u_decode (
    .code  (wait_code_q),
    .waits (waits)
  );

  eaw_cycle_count u_count (
    .clock    (clock),
    .resetn   (resetn),
    .load     (cnt_load),
    .load_val (cnt_val),
    .zero     (cnt_zero)
  );

  always_comb begin
    state_d   = state_q;
    cnt_load  = 1'b0;
    cnt_val   = '0;
    finish    = 1'b0;
    rdata_d   = rdata_q;
    stretch_d = stretch_q;
    case (state_q)
      ST_IDLE: begin
        if (start) begin
          state_d   = ST_SETUP;
          cnt_load  = 1'b1;
          cnt_val   = CNT_W'(EXT_CYC_CLKS - 1);
          stretch_d = 8'h00;
        end
      end
      ST_SETUP: begin
        if (cnt_zero) begin
          cnt_load = 1'b1;
          if (!dir_q && (waits != 5'h00)) begin
            state_d = ST_WAIT;
            cnt_val = CNT_W'(waits * EXT_CYC_CLKS - 1);
          end else begin
            state_d = ST_EXTW;
            cnt_val = CNT_W'(EXT_CYC_CLKS - 1);
          end
        end
      end
      ST_WAIT: begin
        if (cnt_zero) begin
          state_d  = ST_EXTW;
          cnt_load = 1'b1;
          cnt_val  = CNT_W'(EXT_CYC_CLKS - 1);
        end
      end
      ST_EXTW: begin
        if (cnt_zero) begin
          cnt_load = 1'b1;
          if (!external_wait_mask_q && !ext_wait_n) begin
            cnt_val   = CNT_W'(EXT_CYC_CLKS - 1);
            stretch_d = stretch_q + 8'h01;
          end else begin
            state_d = ST_HOLD;
            cnt_val = CNT_W'(HALF_CYC_CLKS - 1 + EXT_CYC_CLKS * hold_q);
            if (!dir_q) begin
              rdata_d = ext_data_i;
            end
          end
        end
      end
      ST_HOLD: begin
        if (cnt_zero) begin
          state_d = ST_IDLE;
          finish  = 1'b1;
        end
      end
      default: state_d = ST_IDLE;
    endcase
  end

  always_comb begin
    ext_addr_d    = (state_d == ST_IDLE) ? ext_addr_q : addr_q;
    ext_data_o_d  = wdata_q;
    ext_data_oe_d = dir_q && (state_d != ST_IDLE);
    area_sel_n_d  = (state_d == ST_IDLE);
    rd_stb_n_d    = !(strobe_phase(state_d) && !dir_q);
    wr_stb_n_d    = !(strobe_phase(state_d) && dir_q);
    lane_n_d      = strobe_phase(state_d) ? ~lanes_q : 2'h3;
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_q       <= ST_IDLE;
      rdata_q       <= 16'h0000;
      stretch_q     <= 8'h00;
      ext_addr_q    <= 16'h0000;
      ext_data_o_q  <= 16'h0000;
      ext_data_oe_q <= 1'b0;
      area_sel_n_q  <= 1'b1;
      rd_stb_n_q    <= 1'b1;
      wr_stb_n_q    <= 1'b1;
      lane_n_q      <= 2'h3;
    end else begin
      state_q       <= state_d;
      rdata_q       <= rdata_d;
      stretch_q     <= stretch_d;
      ext_addr_q    <= ext_addr_d;
      ext_data_o_q  <= ext_data_o_d;
      ext_data_oe_q <= ext_data_oe_d;
      area_sel_n_q  <= area_sel_n_d;
      rd_stb_n_q    <= rd_stb_n_d;
      wr_stb_n_q    <= wr_stb_n_d;
      lane_n_q      <= lane_n_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign hreadyout          = hreadyout_q;
  assign hrdata             = hrdata_q;
  assign hresp              = 1'b0;
  assign ext_addr           = ext_addr_q;
  assign ext_data_o         = ext_data_o_q;
  assign ext_data_oe        = ext_data_oe_q;
  assign area_select_n      = area_sel_n_q;
  assign read_strobe_n      = rd_stb_n_q;
  assign write_strobe_n     = wr_stb_n_q;
  assign byte_lane_strobe_n = lane_n_q;

endmodule : eaw_area_ctrl

// *** verilog/eaw_pkg.sv ***
// Constants shared by the external area wait timing block.
// Assumes a 32-bit AHB-Lite register bus and a 16-bit external parallel bus.
package eaw_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_TIMING  = 8'h00;
  localparam logic [7:0] OFS_ADDR    = 8'h04;
  localparam logic [7:0] OFS_WDATA   = 8'h08;
  localparam logic [7:0] OFS_CTRL    = 8'h0c;
  localparam logic [7:0] OFS_RDATA   = 8'h10;
  localparam logic [7:0] OFS_STRETCH = 8'h14;

  // ---------------------------------------------------------------
  // Timing register fields
  // ---------------------------------------------------------------
  localparam int POS_WAIT_CODE = 7;
  localparam int POS_WAIT_MASK = 6;
  localparam int POS_HOLD      = 0;
  localparam logic [3:0] RST_WAIT_CODE = 4'h2;
  localparam logic       RST_WAIT_MASK = 1'b0;
  localparam logic [1:0] RST_HOLD      = 2'h0;

  // ---------------------------------------------------------------
  // Control register fields
  // ---------------------------------------------------------------
  localparam int POS_START = 0;
  localparam int POS_DIR   = 1;
  localparam int POS_CLEAR = 2;
  localparam int POS_LANES = 4;
  localparam int POS_BUSY  = 0;
  localparam int POS_DONE  = 1;
  localparam logic [1:0] RST_LANES = 2'h3;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 5000;
  localparam int EXT_CYCLE_PS    = 10000;
  localparam int EXT_CYC_CLKS    = (EXT_CYCLE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int HALF_CYC_CLKS   = EXT_CYC_CLKS / 2;
  localparam int CNT_W           = 7;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_WAIT  = 3'b010,
    ST_EXTW  = 3'b011,
    ST_HOLD  = 3'b100
  } eaw_state_t;

endpackage : eaw_pkg

// *** verilog/eaw_wait_decode.sv ***
// Decoder from the 4-bit read wait code to a number of wait cycles.
// Assumes the code comes from a register and is stable during an access.
`timescale 1ns/1ps
module eaw_wait_decode
  import eaw_pkg::*;
(
  input  wire logic [3:0] code,
  output logic      [4:0] waits
);

  // ---------------------------------------------------------------
  // Code table
  // ---------------------------------------------------------------
  always_comb begin
    case (code)
      4'h7:    waits = 5'h08;
      4'h8:    waits = 5'h0a;
      4'h9:    waits = 5'h0c;
      4'ha:    waits = 5'h0e;
      4'hb:    waits = 5'h12;
      4'hc:    waits = 5'h18;
      4'hd,
      4'he,
      4'hf:    waits = 5'h18;
      default: waits = {1'b0, code};
    endcase
  end

endmodule : eaw_wait_decode

// *** verilog/eaw_cycle_count.sv ***
// Down counter that times each phase of an external access.
// Assumes a load is only given when the current phase has ended.
`timescale 1ns/1ps
module eaw_cycle_count
  import eaw_pkg::*;
(
  input  wire logic             clock,
  input  wire logic             resetn,
  input  wire logic             load,
  input  wire logic [CNT_W-1:0] load_val,
  output logic                  zero
);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  // ---------------------------------------------------------------
  // Counter
  // ---------------------------------------------------------------
  always_comb begin
    if (load) begin
      cnt_d = load_val;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CNT_W'(1);
    end else begin
      cnt_d = cnt_q;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign zero = (cnt_q == '0);

endmodule : eaw_cycle_count

// *** verification/eaw_area_monitor.sv ***
// Concurrent checks on the ports of the external area controller.
// Assumes it is bound to eaw_area_ctrl and that hready is hreadyout.
`timescale 1ns/1ps
module eaw_area_monitor (
  input wire logic       clock,
  input wire logic       resetn,
  input wire logic       hsel,
  input wire logic [1:0] htrans,
  input wire logic       hwrite,
  input wire logic [2:0] hsize,
  input wire logic       hready,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       ext_data_oe,
  input wire logic       area_select_n,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic [1:0] byte_lane_strobe_n
);
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [6:0] len_q;
  logic [6:0] len_d;
  always_comb len_d = read_strobe_n ? 7'h00 : len_q + 7'h01;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) len_q <= 7'h00;
    else len_q <= len_d;
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  sequence taken; hsel && htrans[1] && hready && hsize == 3'h2; endsequence
  sequence strobe_off; $rose(read_strobe_n) || $rose(write_strobe_n); endsequence
  a_read_one_wait: assert property (taken and !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read not answered after one wait cycle");
  a_write_no_wait: assert property (taken and hwrite |=> hreadyout)
    else $error("write data phase stalled");
  a_reset_idle: assert property ($rose(resetn) |-> area_select_n && read_strobe_n)
    else $error("external bus not idle after reset");
  a_bus_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  a_strobe_in_sel: assert property (!read_strobe_n || !write_strobe_n |-> !area_select_n)
    else $error("strobe outside area select");
  a_hold_min: assert property (strobe_off |-> !area_select_n)
    else $error("area select dropped with strobe");
  a_hold_max: assert property (strobe_off |-> ##[1:7] area_select_n)
    else $error("area select held too long");
  a_read_even_len: assert property ($rose(read_strobe_n) |-> len_q >= 7'h02 && !len_q[0])
    else $error("read strobe length not whole external cycles");
  a_lane_with_strb: assert property (byte_lane_strobe_n != 2'b11 |->
    !read_strobe_n || !write_strobe_n) else $error("byte lane without strobe");
  a_oe_in_sel: assert property (ext_data_oe |-> !area_select_n && read_strobe_n)
    else $error("data driven outside a write");
endmodule : eaw_area_monitor

bind eaw_area_ctrl eaw_area_monitor u_mon (.clock(clock), .resetn(resetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .ext_data_oe(ext_data_oe), .area_select_n(area_select_n),
  .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
  .byte_lane_strobe_n(byte_lane_strobe_n));

// *** verification/eaw_ext_mem.sv ***
// Model of the external memory on the parallel bus, with a wait output.
// Assumes the bench gives the programmed wait clocks and the stall count.
`timescale 1ns/1ps
module eaw_ext_mem (
  input wire logic        clock,
  input wire logic        area_select_n,
  input wire logic        read_strobe_n,
  input wire logic        write_strobe_n,
  input wire logic [1:0]  byte_lane_strobe_n,
  input wire logic [15:0] ext_addr,
  input wire logic [15:0] ext_data_o,
  input wire logic [6:0]  pre_clks,
  input wire logic [6:0]  stall,
  output logic     [15:0] ext_data_i,
  output logic            ext_wait_n
);
  // ----------------------------------------------------------------
  // Storage and wait
  // ----------------------------------------------------------------
  logic [15:0] mem [16];
  logic [15:0] last = 16'h0000;
  logic [6:0]  c = 7'h00;
  wire strb = !area_select_n && (!read_strobe_n || !write_strobe_n);
  always @(posedge clock) begin
    c <= strb ? c + 7'h01 : 7'h00;
    if (strb && !write_strobe_n) begin
      if (!byte_lane_strobe_n[0]) mem[ext_addr[3:0]][7:0] <= ext_data_o[7:0];
      if (!byte_lane_strobe_n[1]) mem[ext_addr[3:0]][15:8] <= ext_data_o[15:8];
    end
    last <= ext_data_i;
  end
  assign ext_data_i = (strb && !read_strobe_n) ? mem[ext_addr[3:0]] : ~last;
  // Wait is held low for whole external cycles once the programmed waits are over.
  assign ext_wait_n = !(strb && c >= pre_clks && c < pre_clks + 7'(2 * stall));
endmodule : eaw_ext_mem

// *** verification/external_area_wait_timing_tb.sv ***
// Self-checking bench for the external area controller.
// Assumes the controller, its checker and the external memory model.
`timescale 1ns/1ps
module external_area_wait_timing_tb;
  import eaw_pkg::*;
  logic clock, resetn, hsel, hwrite;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic hreadyout, hresp, ext_data_oe, sel_n, rd_n, wr_n, wait_n;
  logic [15:0] ext_addr, ext_data_o, ext_data_i;
  logic [1:0] lanes_n;
  logic [6:0] pre, stall;
  int n_fail = 0, checks_done = 0, cyc = 0, seed = 6722;
  int wtab [13] = '{0, 1, 2, 3, 4, 5, 6, 8, 10, 12, 14, 18, 24};
  // ----------------------------------------------------------------
  // Instances and helpers
  // ----------------------------------------------------------------
  eaw_area_ctrl DUT (.clock(clock), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .ext_addr(ext_addr),
    .ext_data_o(ext_data_o), .ext_data_oe(ext_data_oe), .ext_data_i(ext_data_i),
    .area_select_n(sel_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n),
    .byte_lane_strobe_n(lanes_n), .ext_wait_n(wait_n));
  eaw_ext_mem u_mem (.clock(clock), .area_select_n(sel_n), .read_strobe_n(rd_n),
    .write_strobe_n(wr_n), .byte_lane_strobe_n(lanes_n), .ext_addr(ext_addr),
    .ext_data_o(ext_data_o), .pre_clks(pre), .stall(stall), .ext_data_i(ext_data_i),
    .ext_wait_n(wait_n));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : report_and_stop
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : check
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'b00; hwdata <= wd;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus
  function automatic int exp_len(input int code, input bit wr, input bit msk, input int s);
    return (wr ? 0 : 2 * wtab[code]) + 2 + (msk ? 0 : 2 * s);
  endfunction : exp_len
  // Starts one external access and measures strobe and hold lengths in clocks.
  task automatic access(input bit wr, input logic [1:0] ln, input int p, input int s,
                        output int sl, output int hl);
    logic [31:0] d;
    pre <= 7'(p); stall <= 7'(s);
    bus(1'b1, OFS_CTRL, {26'h0, ln, 2'b01, wr, 1'b1}, d);
    sl = 0; hl = 0;
    while (!(sel_n === 1'b1 && sl > 0)) begin
      @(posedge clock); #1;
      if (rd_n === 1'b0 || wr_n === 1'b0) sl++;
      else if (sel_n === 1'b0 && sl > 0) hl++;
    end
  endtask : access
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] rd, d;
    int m, h, s, sl, hl;
    logic [1:0] ln;
    resetn = 1'b0; hsel = 1'b0; htrans = 2'b00; haddr = '0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = '0; pre = '0; stall = '0;
    repeat (6) @(posedge clock);
    resetn <= 1'b1;
    bus(1'b0, OFS_TIMING, '0, rd); check(rd, 32'h100);
    bus(1'b1, OFS_TIMING, 32'h542, rd);
    bus(1'b0, OFS_TIMING, '0, rd); check(rd, 32'h542);
    bus(1'b1, 8'h18, 32'hffff, rd);
    bus(1'b0, 8'h18, '0, rd); check(rd, 32'h0);
    for (int k = 0; k < 13; k++) begin
      m = k % 2;
      h = $random(seed) & 3;
      s = ($random(seed) & 1) + 1;
      d = $random(seed);
      ln = 2'($random(seed));
      bus(1'b1, OFS_TIMING, (k << 7) | (m << 6) | h, rd);
      bus(1'b1, OFS_ADDR, $random(seed), rd);
      bus(1'b1, OFS_WDATA, d, rd);
      access(1'b1, 2'b11, 0, s, sl, hl);
      check(sl, exp_len(k, 1'b1, m[0], s));
      check(hl, 1 + 2 * h);
      access(1'b0, ln, 2 * wtab[k], s, sl, hl);
      check(sl, exp_len(k, 1'b0, m[0], s));
      check(hl, 1 + 2 * h);
      bus(1'b0, OFS_RDATA, '0, rd); check(rd, {16'h0, d[15:0]});
      bus(1'b0, OFS_CTRL, '0, rd); check(rd, {26'h0, ln, 4'h2});
      bus(1'b0, OFS_STRETCH, '0, rd); check(rd, (m == 0) ? s : 0);
    end
    report_and_stop();
  end
endmodule : external_area_wait_timing_tb
